// ### verilog/ddsl_pkg.sv
// Shared constants of the dual converter serial load logic.
// Assumes a 125 MHz host clock and an 18-bit serial frame, sent as 24 bits in byte mode.
package ddsl_pkg;
  // Frame layout
  localparam int unsigned FRAME_BITS      = 18;
  localparam int unsigned BYTE_FRAME_BITS = 24;
  localparam int unsigned CODE_BITS       = 16;
  localparam int unsigned SEL_LO_POS      = 16;
  localparam int unsigned SEL_HI_POS      = 17;
  localparam int unsigned CHANNELS        = 2;
  // Preset codes
  localparam logic [15:0] PRESET_ZERO = 16'h0000;
  localparam logic [15:0] PRESET_HALF = 16'h8000;
  // Host register offsets (byte addresses)
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_DATA   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_PINS   = 4'hc;
  // Control register fields
  localparam int unsigned CTRL_START_POS = 0;
  localparam int unsigned CTRL_BYTE_POS  = 1;
  localparam int unsigned CTRL_SLO_POS   = 2;
  localparam int unsigned CTRL_SHI_POS   = 3;
  // Status and pin register fields
  localparam int unsigned STAT_BUSY_POS  = 0;
  localparam int unsigned PIN_LOAD_POS   = 0;
  localparam int unsigned PIN_PRESET_POS = 1;
  localparam int unsigned PIN_MSB_POS    = 2;
  // Reset values
  localparam logic [2:0]  PINS_RESET = 3'h3;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  // Link timing
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned SCLK_HALF_NS  = 80;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ### verilog/ddsl_link_if.sv
// Serial link and hardware control pins between host and converter.
// Assumes the host end drives every wire; the device end only listens.
`timescale 1ns/10ps
`default_nettype none
interface ddsl_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic dac_load_strobe_n;
  logic async_preset_n;
  logic msb_level;
  modport host (output cs_n, output sclk, output sdi,
                output dac_load_strobe_n, output async_preset_n, output msb_level);
  modport dev  (input cs_n, input sclk, input sdi,
                input dac_load_strobe_n, input async_preset_n, input msb_level);
endinterface
`default_nettype wire

// ### verilog/ddsl_device.sv
// Converter end: shift register, input registers and DAC registers.
// Assumes the link clock stops outside frames; chip select edges end frames.
`timescale 1ns/10ps
`default_nettype none
module ddsl_device
  import ddsl_pkg::*;
(
  // Link from host
  ddsl_link_if.dev             link,
  // Power-on reset pulse
  input  wire logic            por_n,
  // Converter codes
  output logic [15:0]          dac_a_code,
  output logic [15:0]          dac_b_code
);
  import ddsl_pkg::*;

  logic [FRAME_BITS-1:0] shift_q;
  logic                  preset_any_n;
  logic [15:0]           preset_val;
  logic [15:0]           dac_q [CHANNELS];

  // Preset source and level
  assign preset_any_n = link.async_preset_n & por_n;
  assign preset_val   = link.msb_level ? PRESET_HALF : PRESET_ZERO;

  // Serial shift register; excess leading bits fall off the top
  always_ff @(posedge link.sclk)
  begin
    if (!link.cs_n)
      shift_q <= {shift_q[FRAME_BITS-2:0], link.sdi};
  end

  // Per-channel input and DAC registers
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      logic [15:0] code_q;
      logic        fresh_q;
      logic [15:0] in_val;

      // Input register loaded on chip select rise
      always_ff @(posedge link.cs_n or negedge preset_any_n)
      begin
        if (!preset_any_n)
        begin
          code_q  <= PRESET_ZERO;
          fresh_q <= 1'b1;
        end
        else if (shift_q[SEL_LO_POS + ch])
        begin
          code_q  <= shift_q[CODE_BITS-1:0];
          fresh_q <= 1'b0;
        end
      end

      // Preset value stands until a real load
      assign in_val = fresh_q ? preset_val : code_q;

      // DAC register, transparent while strobe low
      always_latch
      begin
        if (!preset_any_n)
          dac_q[ch] = preset_val;
        else if (!link.dac_load_strobe_n)
          dac_q[ch] = in_val;
      end
    end
  endgenerate

  // Channel outputs
  assign dac_a_code = dac_q[0];
  assign dac_b_code = dac_q[1];
endmodule
`default_nettype wire

// ### verilog/ddsl_host.sv
// Host end: Avalon-MM register slave that sends serial frames.
// Assumes a 125 MHz clock; serial clock is divided down from it.
`timescale 1ns/10ps
`default_nettype none
module ddsl_host
  import ddsl_pkg::*;
#(
  parameter int unsigned SCLK_HALF = ddsl_pkg::SCLK_HALF_CYC
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]      address,
  input  wire logic            read,
  input  wire logic            write,
  input  wire logic [31:0]     writedata,
  output logic [31:0]          readdata,
  output logic                 waitrequest,
  // Link to converter
  ddsl_link_if.host            link
);
  import ddsl_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LO, ST_HI, ST_TAIL} ddsl_state_e;

  ddsl_state_e state_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        commit;
  logic        byte_q;
  logic [1:0]  sel_q;
  logic [15:0] data_q;
  logic [2:0]  pins_q;
  logic [23:0] word_q;
  logic [23:0] word_d;
  logic [4:0]  bits_q;
  logic [7:0]  cnt_q;
  logic        sclk_q;
  logic        cs_n_q;
  logic        sdi_q;
  logic        start;
  logic        half_done;

  // Bus handshake: one wait cycle, then commit
  assign commit    = (read | write) & ~wait_q;
  assign start     = commit & write & (address == OFS_CTRL) & writedata[CTRL_START_POS] & (state_q == ST_IDLE);
  assign half_done = (cnt_q == 8'(SCLK_HALF - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      wait_q <= 1'b1;
    else
      wait_q <= ~((read | write) & wait_q);
  end

  // Read data prepared during the wait cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (read & wait_q)
    begin
      case (address)
        OFS_CTRL:   rdata_q <= {28'h0, sel_q, byte_q, 1'b0};
        OFS_DATA:   rdata_q <= {16'h0, data_q};
        OFS_STATUS: rdata_q <= {31'h0, state_q != ST_IDLE};
        OFS_PINS:   rdata_q <= {29'h0, pins_q};
        default:    rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Register writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      byte_q <= 1'b0;
      sel_q  <= 2'h0;
      data_q <= DATA_RESET;
      pins_q <= PINS_RESET;
    end
    else if (commit & write)
    begin
      if (address == OFS_CTRL && state_q == ST_IDLE)
      begin
        byte_q <= writedata[CTRL_BYTE_POS];
        sel_q  <= writedata[CTRL_SHI_POS:CTRL_SLO_POS];
      end
      if (address == OFS_DATA)
        data_q <= writedata[15:0];
      if (address == OFS_PINS)
        pins_q <= writedata[2:0];
    end
  end

  // Frame word from the start write: left-aligned in 24 bits, or right-aligned behind 6 zero bits in byte mode
  always_comb
  begin
    if (writedata[CTRL_BYTE_POS])
      word_d = {6'h00, writedata[CTRL_SHI_POS], writedata[CTRL_SLO_POS], data_q};
    else
      word_d = {writedata[CTRL_SHI_POS], writedata[CTRL_SLO_POS], data_q, 6'h00};
  end

  // Frame sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      word_q  <= 24'h000000;
      bits_q  <= 5'h00;
      cnt_q   <= 8'h00;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      sdi_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (start)
          begin
            sdi_q   <= word_d[23];
            word_q  <= {word_d[22:0], 1'b0};
            bits_q  <= writedata[CTRL_BYTE_POS] ? 5'(BYTE_FRAME_BITS) : 5'(FRAME_BITS);
            cs_n_q  <= 1'b0;
            cnt_q   <= 8'h00;
            state_q <= ST_LO;
          end
        ST_LO:
          if (half_done)
          begin
            sclk_q  <= 1'b1;
            cnt_q   <= 8'h00;
            state_q <= ST_HI;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        ST_HI:
          if (half_done)
          begin
            sclk_q <= 1'b0;
            cnt_q  <= 8'h00;
            bits_q <= bits_q - 5'h01;
            if (bits_q == 5'h01)
              state_q <= ST_TAIL;
            else
            begin
              sdi_q   <= word_q[23];
              word_q  <= {word_q[22:0], 1'b0};
              state_q <= ST_LO;
            end
          end
          else
            cnt_q <= cnt_q + 8'h01;
        ST_TAIL:
          if (half_done)
          begin
            cs_n_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 8'h01;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Outputs straight from flops
  assign readdata               = rdata_q;
  assign waitrequest            = wait_q;
  assign link.cs_n              = cs_n_q;
  assign link.sclk              = sclk_q;
  assign link.sdi               = sdi_q;
  assign link.dac_load_strobe_n = pins_q[PIN_LOAD_POS];
  assign link.async_preset_n    = pins_q[PIN_PRESET_POS];
  assign link.msb_level         = pins_q[PIN_MSB_POS];
endmodule
`default_nettype wire

// ### bench/ddsl_link_chk.sv
// Checker of the serial link and converter codes.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module ddsl_link_chk #(
  parameter int HALF = 2
)
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Link wires
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic        sdi,
  input wire logic        dac_load_strobe_n,
  input wire logic        async_preset_n,
  input wire logic        msb_level,
  // Converter side
  input wire logic        por_n,
  input wire logic [15:0] dac_a_code,
  input wire logic [15:0] dac_b_code
);
  logic       sclk_q;
  logic [4:0] bits_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Rising serial clock edges in the current frame
  always_ff @(posedge clk)
  begin
    sclk_q <= sclk;
    if (!rst_n || cs_n)
      bits_q <= 5'h0;
    else if (sclk && !sclk_q)
      bits_q <= bits_q + 5'h1;
  end
  idle_sclk_a: assert property (cs_n |-> !sclk)
    else $error("clock outside frame");
  sdi_hold_a: assert property (sclk |-> $stable(sdi))
    else $error("data moved while clock high");
  rise_sel_a: assert property ($rose(sclk) |-> !cs_n)
    else $error("clock rise without select");
  bit_count_a: assert property ($rose(cs_n) |-> bits_q == 5'd18 || bits_q == 5'd24)
    else $error("wrong frame length");
  half_period_a: assert property ($rose(sclk) |-> ##HALF $fell(sclk))
    else $error("clock high time wrong");
  frame_edge_a: assert property ($changed(cs_n) |-> !sclk)
    else $error("select moved with clock high");
  preset_val_a: assert property (!async_preset_n && !$past(async_preset_n)
    |-> {dac_a_code, dac_b_code} == {2{msb_level ? 16'h8000 : 16'h0000}}) else $error("preset code wrong");
  dac_hold_a: assert property (dac_load_strobe_n && $past(dac_load_strobe_n) && async_preset_n
    && $past(async_preset_n) && por_n && $past(por_n) |-> $stable({dac_a_code, dac_b_code}))
    else $error("codes moved while held");
endmodule
`default_nettype wire

// ### bench/tb_dual_dac_serial_load_logic.sv
// Bench joining host and converter ends over the link.
// Assumes a 125 MHz clock and a shortened serial clock divider.
`timescale 1ns/10ps
`default_nettype none
module tb_dual_dac_serial_load_logic;
  import ddsl_pkg::*;
  logic        clk = 0, rst_n = 0, por_n = 0, read = 0, write = 0, waitrequest;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic [15:0] dac_a_code, dac_b_code, in_a = 0, in_b = 0, da = 0, db = 0, rnd = 16'h4bde;
  logic [2:0]  pins = 3'h3;
  logic [31:0] rq[$], dq[$];
  int          n_fail = 0, comparisons = 0;
  event        probe;
  ddsl_link_if link();
  ddsl_host #(.SCLK_HALF(2)) ddsl_host_i (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .link(link));
  ddsl_device ddsl_device_i (.link(link), .por_n(por_n), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));
  ddsl_link_chk #(.HALF(2)) ddsl_link_chk_i (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .sdi(link.sdi), .dac_load_strobe_n(link.dac_load_strobe_n), .async_preset_n(link.async_preset_n),
    .msb_level(link.msb_level), .por_n(por_n), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));
  always #4 clk = ~clk;
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Bus cycle held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Expected codes after a pin or frame change
  task automatic upd;
    if (!pins[PIN_PRESET_POS])
    begin
      in_a = pins[PIN_MSB_POS] ? PRESET_HALF : PRESET_ZERO;
      in_b = in_a;
    end
    if (!pins[PIN_PRESET_POS] || !pins[PIN_LOAD_POS])
    begin
      da = in_a;
      db = in_b;
    end
    dq.push_back({da, db});
  endtask
  task automatic setp(input logic [2:0] p);
    pins = p;
    upd();
    bus(1'b1, OFS_PINS, {29'h0, p});
    repeat (2) @(posedge clk);
    -> probe;
  endtask
  task automatic frame(input logic [1:0] sel, input logic bm, input logic [15:0] code);
    if (sel[0])
      in_a = code;
    if (sel[1])
      in_b = code;
    upd();
    bus(1'b1, OFS_DATA, {16'h0, code});
    bus(1'b1, OFS_CTRL, {28'h0, sel, bm, 1'b1});
    rd(OFS_STATUS, 32'h1);
    @(posedge link.cs_n);
  endtask
  // Result watchers
  always @(posedge clk)
    if (read && !waitrequest)
      check(readdata, rq.pop_front());
  always @(posedge link.cs_n or probe)
  begin
    repeat (3) @(posedge clk);
    if (dq.size() > 0)
      check({dac_a_code, dac_b_code}, dq.pop_front());
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rd(OFS_PINS, {29'h0, PINS_RESET});
    rd(4'h6, 32'h0);
    setp(3'h3);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      frame(i[1:0], i[2], rnd);
      if (i == 3)
        setp(3'h2);
    end
    setp(3'h5);
    setp(3'h7);
    setp(3'h1);
    setp(3'h3);
    repeat (6) @(posedge clk);
    print_verdict();
  end
  initial
  begin
    #500000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
